// file: logic/pwi_pkg.sv
// package of constants and types for the pwm waveform interpolator
package pwi_pkg;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_CONFIG = 7'h00;
  localparam logic [6:0] IDX_WRAP = 7'h02;
  localparam logic [6:0] IDX_TABLE_BASE = 7'h04;
  localparam logic [6:0] IDX_TRIG = 7'h06;
  localparam logic [6:0] IDX_SPEED = 7'h08;
  localparam logic [6:0] IDX_PHASE = 7'h0A;
  localparam logic [6:0] IDX_ANGLE = 7'h0C;
  localparam logic [6:0] IDX_SHADOW = 7'h1C;
  // per channel block: channel n sits at index (3+n)*16 plus a sub index
  localparam logic [2:0] CHAN_BLOCK_FIRST = 3'h3;
  localparam logic [3:0] SUB_OFFSET = 4'h0;
  localparam logic [3:0] SUB_LOW = 4'h2;
  localparam logic [3:0] SUB_HIGH = 4'h4;
  localparam logic [3:0] SUB_LOW_RLD = 4'h6;
  localparam logic [3:0] SUB_HIGH_RLD = 4'h8;
  // configuration bit positions
  localparam int CFG_SPEED_EN = 0;
  localparam int CFG_DMA_EN = 1;
  localparam int CFG_LOW_ON = 2;
  localparam int CFG_HIGH_ON = 3;
  localparam int CFG_PAIR_SWAP = 4;
  localparam int CFG_PACING = 5;
  // trigger bit positions
  localparam int TRG_SYNC = 0;
  localparam int TRG_RELOAD0 = 1;
  localparam int TRG_DMA0 = 4;
  localparam int TRG_SCALE = 7;
  // reset values
  localparam logic [5:0] CONFIG_RESET = 6'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [17:0] PHASE_RESET = 18'h00000;
  localparam logic [11:0] ANGLE_RESET = 12'h000;
  // table entry fields and dma address step
  localparam int TBL_ON = 31;
  localparam int TBL_SLOPE_MSB = 15;
  localparam int TBL_SLOPE_LSB = 9;
  localparam int TBL_DUR_MSB = 8;
  localparam logic [15:0] DMA_STEP = 16'h0004;
  localparam logic [8:0] DUR_RELOAD_BELOW = 9'h002;
  // signals toward one pwm channel
  typedef struct packed {
    logic high_side;
    logic low_side;
    logic [15:0] amp;
  } pwi_chan_type;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_CALC = 2'b01,
    SC_HAND = 2'b10
  } pwi_scale_state_type;
endpackage : pwi_pkg

// file: logic/pwi_waveform_interpolator.sv
// pwm waveform interpolator: phase counter, three line channels, dma refill, scaler
`timescale 1ns/10ps
`default_nettype none
module pwi_waveform_interpolator #(
  parameter logic [15:0] SCALE_OFFSET = 16'h0000,
  parameter logic [15:0] SCALE_MUL = 16'h0001,
  parameter logic [4:0] SCALE_SHIFT = 5'h00
) (
  input wire logic CLOCK_I, // system clock
  input wire logic RESETN_I, // synchronous reset, active low
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb enable
  input wire logic PWRITE_I, // apb direction
  input wire logic [11:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error on unmapped address
  output logic DMA_REQ_O, // memory read request
  output logic [15:0] DMA_ADDR_O, // memory read address
  input wire logic DMA_GNT_I, // grant, read data valid
  input wire logic [31:0] DMA_RDATA_I, // table entry
  input wire logic PWM_RELOAD_I, // pwm reload event pulse
  input wire logic PWM_ACK_I, // pwm takes the values
  output pwi_pkg::pwi_chan_type [2:0] PWM_CH_O, // values per pwm channel
  output logic PWM_VALID_O, // new amplitudes offered
  output logic [11:0] ANGLE_O, // electrical angle to adc control
  output logic IRQ_O // module interrupt pulse
);
  import pwi_pkg::*;

  logic [5:0] cfg_ff, nxt_cfg;
  logic [11:0] wrap_ff, nxt_wrap, angle_ff, nxt_angle;
  logic [15:0] speed_ff, nxt_speed, shadow_ff, nxt_shadow, base_ff, nxt_base;
  logic shadow_wr_ff, nxt_shadow_wr;
  logic [17:0] phase_ff, nxt_phase;
  logic [15:0] off_ff [3], nxt_off [3];
  logic [15:0] low_ff [3], nxt_low [3];
  logic [15:0] high_ff [3], nxt_high [3];
  logic [15:0] low_rld_ff [3], nxt_low_rld [3];
  logic [15:0] high_rld_ff [3], nxt_high_rld [3];
  logic [2:0] fresh_ff, nxt_fresh, pend_ff, nxt_pend, pend_set, pend_clr, rld_evt;
  logic busy_ff, nxt_busy, irq_ff, nxt_irq, reload_err;
  logic [1:0] dch_ff, nxt_dch;
  logic [15:0] daddr_ff, nxt_daddr;
  logic [18:0] phase_sum;
  logic step, setup, wr;
  logic [6:0] idx;
  logic [7:0] trig;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  pwi_scale_state_type st_ff, nxt_st;
  logic [1:0] sidx_ff, nxt_sidx;
  logic spend_ff, nxt_spend, valid_ff, nxt_valid, scale_trig;
  logic [15:0] amp_ff [3], nxt_amp [3];
  pwi_chan_type [2:0] out_ff, nxt_out;

  // channel number of an index, 3 when not a channel block
  function automatic logic [1:0] chan_of(input logic [6:0] i);
    chan_of = (i[6:4] >= CHAN_BLOCK_FIRST) && (i[6:4] < CHAN_BLOCK_FIRST + 3'h3) ?
      2'(i[6:4] - CHAN_BLOCK_FIRST) : 2'h3;
  endfunction : chan_of

  // line value to pwm reload value: offset, multiply, shift, limit
  function automatic logic [15:0] scale_fn(input logic [14:0] v);
    logic [16:0] s;
    logic [32:0] p;
    s = 17'(v) + 17'(SCALE_OFFSET);
    p = 33'(s) * 33'(SCALE_MUL);
    p = p >> SCALE_SHIFT;
    scale_fn = (|p[32:16]) ? 16'hFFFF : p[15:0];
  endfunction : scale_fn

  // bus decode, command strobes and phase overflow
  assign setup = PSEL_I && !PENABLE_I;
  assign wr = PSEL_I && PENABLE_I && pready_ff && PWRITE_I;
  assign idx = PADDR_I[8:2];
  assign trig = (wr && idx == IDX_TRIG) ? PWDATA_I[7:0] : 8'h00;
  assign phase_sum = 19'(phase_ff) + 19'(speed_ff);
  assign step = cfg_ff[CFG_SPEED_EN] && phase_sum[18];

  // apb answer: captured in setup, ready in the access cycle
  always_comb
  begin
    logic [1:0] c;
    logic [3:0] sub;
    logic hit;
    c = chan_of(idx);
    sub = idx[3:0];
    hit = 1'b1;
    nxt_prdata = 32'h00000000;
    if (c != 2'h3)
    begin
      unique case (sub)
        SUB_OFFSET: nxt_prdata[15:0] = off_ff[c];
        SUB_LOW: nxt_prdata[15:0] = low_ff[c];
        SUB_HIGH: nxt_prdata[15:0] = high_ff[c];
        SUB_LOW_RLD: nxt_prdata[15:0] = low_rld_ff[c];
        SUB_HIGH_RLD: nxt_prdata[15:0] = high_rld_ff[c];
        default: hit = 1'b0;
      endcase
    end
    else
    begin
      unique case (idx)
        IDX_CONFIG: nxt_prdata[5:0] = cfg_ff;
        IDX_WRAP: nxt_prdata[11:0] = wrap_ff;
        IDX_TABLE_BASE: nxt_prdata[15:0] = base_ff;
        IDX_TRIG: nxt_prdata = 32'h00000000;
        IDX_SPEED: nxt_prdata[15:0] = speed_ff;
        IDX_PHASE: nxt_prdata[15:0] = phase_ff[17:2];
        IDX_ANGLE: nxt_prdata[11:0] = angle_ff;
        IDX_SHADOW: nxt_prdata[15:0] = shadow_ff;
        default: hit = 1'b0;
      endcase
    end
    if (PADDR_I[11:9] != 3'h0 || PADDR_I[1:0] != 2'h0)
      hit = 1'b0;
    if (!hit)
      nxt_prdata = 32'h00000000;
    nxt_pready = setup;
    nxt_pslverr = setup && !hit;
  end

  // phase, angle, speed, channels and dma refill next state
  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_wrap = wrap_ff;
    nxt_base = base_ff;
    nxt_speed = speed_ff;
    nxt_shadow = shadow_ff;
    nxt_shadow_wr = shadow_wr_ff;
    nxt_phase = phase_ff;
    nxt_angle = angle_ff;
    nxt_off = off_ff;
    nxt_low = low_ff;
    nxt_high = high_ff;
    nxt_low_rld = low_rld_ff;
    nxt_high_rld = high_rld_ff;
    nxt_fresh = fresh_ff;
    nxt_busy = busy_ff;
    nxt_dch = dch_ff;
    nxt_daddr = daddr_ff;
    pend_set = 3'h0;
    pend_clr = 3'h0;
    reload_err = 1'b0;
    if (cfg_ff[CFG_SPEED_EN])
      nxt_phase = phase_sum[17:0];
    if (step)
      nxt_angle = (angle_ff == wrap_ff) ? ANGLE_RESET : angle_ff + 12'h001;
    if (trig[TRG_SYNC] && shadow_wr_ff)
    begin
      nxt_speed = shadow_ff;
      nxt_shadow_wr = 1'b0;
    end
    for (int c = 0; c < 3; c++)
    begin
      rld_evt[c] = (step && low_ff[c][TBL_DUR_MSB:0] < DUR_RELOAD_BELOW) ||
        trig[TRG_RELOAD0 + c];
      if (rld_evt[c])
      begin
        nxt_low[c] = low_rld_ff[c];
        nxt_high[c] = high_rld_ff[c];
        nxt_fresh[c] = 1'b0;
        reload_err = reload_err || !fresh_ff[c];
        pend_set[c] = cfg_ff[CFG_DMA_EN];
      end
      else if (step)
      begin
        // unsigned line value wraps freely
        nxt_high[c][14:0] = high_ff[c][14:0] +
          {{8{low_ff[c][TBL_SLOPE_MSB]}}, low_ff[c][TBL_SLOPE_MSB:TBL_SLOPE_LSB]};
        nxt_low[c][TBL_DUR_MSB:0] = low_ff[c][TBL_DUR_MSB:0] - 9'h001;
      end
      if (trig[TRG_DMA0 + c])
        pend_set[c] = 1'b1;
    end
    // software writes
    if (wr)
    begin
      unique case (idx)
        IDX_CONFIG: nxt_cfg = PWDATA_I[5:0];
        IDX_WRAP: nxt_wrap = PWDATA_I[11:0];
        IDX_TABLE_BASE: nxt_base = PWDATA_I[15:0];
        IDX_SPEED: nxt_speed = PWDATA_I[15:0];
        IDX_PHASE: nxt_phase = {PWDATA_I[15:0], 2'b00};
        IDX_ANGLE: nxt_angle = PWDATA_I[11:0];
        IDX_SHADOW:
        begin
          nxt_shadow = PWDATA_I[15:0];
          nxt_shadow_wr = 1'b1;
        end
        default: ;
      endcase
      if (chan_of(idx) != 2'h3)
      begin
        unique case (idx[3:0])
          SUB_OFFSET: nxt_off[chan_of(idx)] = PWDATA_I[15:0];
          SUB_LOW: nxt_low[chan_of(idx)] = PWDATA_I[15:0];
          SUB_HIGH: nxt_high[chan_of(idx)] = PWDATA_I[15:0];
          SUB_LOW_RLD:
          begin
            nxt_low_rld[chan_of(idx)] = PWDATA_I[15:0];
            nxt_fresh[chan_of(idx)] = 1'b1;
          end
          SUB_HIGH_RLD:
          begin
            nxt_high_rld[chan_of(idx)] = PWDATA_I[15:0];
            nxt_fresh[chan_of(idx)] = 1'b1;
          end
          default: ;
        endcase
      end
    end
    // dma refill, one channel at a time
    if (busy_ff && DMA_GNT_I)
    begin
      if (DMA_RDATA_I[TBL_DUR_MSB:0] == 9'h000)
      begin
        nxt_off[dch_ff] = WORD_RESET;
        nxt_daddr = base_ff;
      end
      else
      begin
        nxt_high_rld[dch_ff] = DMA_RDATA_I[TBL_ON:16];
        nxt_low_rld[dch_ff] = DMA_RDATA_I[15:0];
        nxt_off[dch_ff] = off_ff[dch_ff] + DMA_STEP;
        nxt_fresh[dch_ff] = 1'b1;
        nxt_busy = 1'b0;
      end
    end
    else if (!busy_ff && |pend_ff)
    begin
      nxt_dch = pend_ff[0] ? 2'h0 : (pend_ff[1] ? 2'h1 : 2'h2);
      nxt_daddr = base_ff + off_ff[nxt_dch];
      nxt_busy = 1'b1;
      pend_clr[nxt_dch] = 1'b1;
    end
    nxt_pend = (pend_ff & ~pend_clr) | pend_set;
    nxt_irq = (|rld_evt) || reload_err || trig[TRG_SYNC];
  end

  // scaler sequencing and outputs toward the pwm module
  always_comb
  begin
    int src;
    src = 0;
    nxt_st = st_ff;
    nxt_sidx = sidx_ff;
    nxt_amp = amp_ff;
    nxt_valid = valid_ff;
    scale_trig = (cfg_ff[CFG_PACING] ? PWM_RELOAD_I : step) || trig[TRG_SCALE];
    nxt_spend = spend_ff || scale_trig;
    unique case (st_ff)
      SC_IDLE:
        if (nxt_spend)
        begin
          nxt_st = SC_CALC;
          nxt_sidx = 2'h0;
          nxt_spend = 1'b0; // this pass consumes every merged trigger
        end
      SC_CALC:
      begin
        nxt_amp[sidx_ff] = scale_fn(high_ff[sidx_ff][14:0]);
        nxt_sidx = sidx_ff + 2'h1;
        if (sidx_ff == 2'h2)
          nxt_st = SC_HAND;
      end
      SC_HAND:
      begin
        nxt_valid = 1'b1;
        if (valid_ff && PWM_ACK_I)
        begin
          nxt_valid = 1'b0;
          nxt_st = SC_IDLE;
        end
      end
      default: nxt_st = SC_IDLE;
    endcase
    for (int o = 0; o < 3; o++)
    begin
      src = (cfg_ff[CFG_PAIR_SWAP] && o < 2) ? 1 - o : o;
      nxt_out[o].amp = amp_ff[src];
      nxt_out[o].high_side = high_ff[src][15] ? cfg_ff[CFG_HIGH_ON] : 1'b1;
      nxt_out[o].low_side = high_ff[src][15] ? cfg_ff[CFG_LOW_ON] : 1'b1;
    end
  end

  // register all state
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      cfg_ff <= CONFIG_RESET;
      wrap_ff <= ANGLE_RESET;
      base_ff <= WORD_RESET;
      speed_ff <= WORD_RESET;
      shadow_ff <= WORD_RESET;
      shadow_wr_ff <= 1'b0;
      phase_ff <= PHASE_RESET;
      angle_ff <= ANGLE_RESET;
      for (int c = 0; c < 3; c++)
      begin
        off_ff[c] <= WORD_RESET;
        low_ff[c] <= WORD_RESET;
        high_ff[c] <= WORD_RESET;
        low_rld_ff[c] <= WORD_RESET;
        high_rld_ff[c] <= WORD_RESET;
        amp_ff[c] <= WORD_RESET;
      end
      fresh_ff <= 3'h0;
      pend_ff <= 3'h0;
      busy_ff <= 1'b0;
      dch_ff <= 2'h0;
      daddr_ff <= WORD_RESET;
      irq_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      st_ff <= SC_IDLE;
      sidx_ff <= 2'h0;
      spend_ff <= 1'b0;
      valid_ff <= 1'b0;
      out_ff <= '0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      wrap_ff <= nxt_wrap;
      base_ff <= nxt_base;
      speed_ff <= nxt_speed;
      shadow_ff <= nxt_shadow;
      shadow_wr_ff <= nxt_shadow_wr;
      phase_ff <= nxt_phase;
      angle_ff <= nxt_angle;
      off_ff <= nxt_off;
      low_ff <= nxt_low;
      high_ff <= nxt_high;
      low_rld_ff <= nxt_low_rld;
      high_rld_ff <= nxt_high_rld;
      amp_ff <= nxt_amp;
      fresh_ff <= nxt_fresh;
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
      dch_ff <= nxt_dch;
      daddr_ff <= nxt_daddr;
      irq_ff <= nxt_irq;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      st_ff <= nxt_st;
      sidx_ff <= nxt_sidx;
      spend_ff <= nxt_spend;
      valid_ff <= nxt_valid;
      out_ff <= nxt_out;
    end
  end

  // outputs straight from flip-flops
  assign PRDATA_O = prdata_ff;
  assign PREADY_O = pready_ff;
  assign PSLVERR_O = pslverr_ff;
  assign DMA_REQ_O = busy_ff;
  assign DMA_ADDR_O = daddr_ff;
  assign PWM_CH_O = out_ff;
  assign PWM_VALID_O = valid_ff;
  assign ANGLE_O = angle_ff;
  assign IRQ_O = irq_ff;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  // checks on the guarded logic
  a_dur_count_down: assert property (
    (step && low_ff[0][8:0] >= DUR_RELOAD_BELOW && !wr && !trig[TRG_RELOAD0])
    |=> low_ff[0][8:0] == $past(low_ff[0][8:0]) - 9'h001)
    else $error("duration did not count down on step");
  a_reload_copy: assert property (
    (rld_evt[1] && !(wr && chan_of(idx) == 2'h1))
    |=> high_ff[1] == $past(high_rld_ff[1]) && low_ff[1] == $past(low_rld_ff[1]))
    else $error("reload words not copied");
  a_phase_write: assert property (
    (wr && idx == IDX_PHASE) |=> phase_ff == {$past(PWDATA_I[15:0]), 2'b00})
    else $error("phase write wrong");
  a_phase_hold: assert property (
    (!cfg_ff[CFG_SPEED_EN] && !wr) |=> $stable(phase_ff))
    else $error("phase moved while disabled");
  a_angle_wrap: assert property (
    (step && angle_ff == wrap_ff && !wr) |=> ANGLE_O == 12'h000)
    else $error("angle did not wrap");
  a_sync_speed: assert property (
    (trig[TRG_SYNC] && !shadow_wr_ff) |=> $stable(speed_ff))
    else $error("speed loaded without shadow write");
  a_dma_req_hold: assert property (
    (DMA_REQ_O && !DMA_GNT_I) |=> DMA_REQ_O && $stable(DMA_ADDR_O))
    else $error("dma request dropped before grant");
  a_pair_swap: assert property (
    cfg_ff[CFG_PAIR_SWAP] |=> PWM_CH_O[0].amp == $past(amp_ff[1]))
    else $error("channel exchange missing");
  a_reload_irq: assert property (
    (|rld_evt) |=> IRQ_O)
    else $error("reload event without interrupt");
  a_irq_quiet: assert property (
    (!(|rld_evt) && !reload_err && !trig[TRG_SYNC]) |=> !IRQ_O)
    else $error("interrupt without event");
  a_scale_spacing: assert property (
    (st_ff == SC_IDLE && nxt_st == SC_CALC)
    |=> st_ff == SC_CALC [*3] ##1 st_ff == SC_HAND ##1 PWM_VALID_O)
    else $error("scaler sequence wrong");
endmodule : pwi_waveform_interpolator
`default_nettype wire

// file: verif/pwi_far_model.sv
// far side model: table memory behind the dma read port and an acking pwm unit
`timescale 1ns/10ps
`default_nettype none
module pwi_far_model (
  input wire logic clk_i, // system clock
  input wire logic dma_req_i, // refill request
  input wire logic [15:0] dma_addr_i, // table address
  output logic dma_gnt_o, // grant with data
  output logic [31:0] dma_rdata_o, // table word
  input wire logic pwm_valid_i, // amplitudes offered
  output logic pwm_ack_o, // amplitudes taken
  input wire logic [3:0] wait_i, // grant and ack delay
  input wire logic reload_cmd_i, // bench asks for a pwm reload
  output logic pwm_reload_o // pwm reload pulse
);
  logic [3:0] dcnt = 4'h0;
  logic [3:0] pcnt = 4'h0;
  // three rising lines, then an end entry with zero duration
  function automatic logic [31:0] entry(input logic [15:0] a);
    return (a[7:0] >= 8'h0C) ? 32'h0 : {8'h10, a[7:0], 7'h02, 9'h003};
  endfunction : entry
  // outputs idle low at start
  initial
  begin
    dma_gnt_o = 1'b0;
    dma_rdata_o = 32'h0;
    pwm_ack_o = 1'b0;
    pwm_reload_o = 1'b0;
  end
  // one grant per wait, released data toggles so it matches the last word only every other cycle
  always @(posedge clk_i)
  begin
    dma_gnt_o <= 1'b0;
    dma_rdata_o <= ~dma_rdata_o;
    dcnt <= dma_req_i ? dcnt + 4'h1 : 4'h0;
    if (dma_req_i && !dma_gnt_o && dcnt >= wait_i)
    begin
      dma_gnt_o <= 1'b1;
      dma_rdata_o <= entry(dma_addr_i);
      dcnt <= 4'h0;
    end
    pwm_ack_o <= 1'b0;
    pcnt <= pwm_valid_i ? pcnt + 4'h1 : 4'h0;
    if (pwm_valid_i && !pwm_ack_o && pcnt >= wait_i)
    begin
      pwm_ack_o <= 1'b1;
      pcnt <= 4'h0;
    end
    pwm_reload_o <= reload_cmd_i;
  end
endmodule : pwi_far_model
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the pwm waveform interpolator
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  import pwi_pkg::*;
  typedef struct {logic rd; logic [31:0] dat; logic err;} pwi_note_type;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, drdata, r;
  logic pready, pslverr, dreq, dgnt, pvalid, pack, preload, irq;
  logic reload_cmd = 1'b0;
  logic [15:0] daddr;
  logic [3:0] far_wait = 4'h0;
  logic [11:0] angle, prev_angle;
  logic [11:0] lim = 12'h000;
  pwi_chan_type [2:0] pwm_ch, last, e;
  pwi_note_type nt;
  pwi_note_type bus_q[$];
  pwi_chan_type [2:0] pwm_q[$];
  logic [6:0] regs[7] = '{IDX_CONFIG, IDX_WRAP, IDX_TRIG, IDX_SPEED, IDX_PHASE, IDX_ANGLE,
    IDX_SHADOW};
  int err_count = 0;
  int samples_checked = 0;
  int grants = 0;
  int irqs = 0;
  int steps = 0;
  int cyc = 0;
  int b;
  // clock of 25 ns
  always #12.5 clk = ~clk;
  pwi_waveform_interpolator uut (.CLOCK_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .DMA_REQ_O(dreq),
    .DMA_ADDR_O(daddr), .DMA_GNT_I(dgnt), .DMA_RDATA_I(drdata), .PWM_RELOAD_I(preload),
    .PWM_ACK_I(pack), .PWM_CH_O(pwm_ch), .PWM_VALID_O(pvalid), .ANGLE_O(angle), .IRQ_O(irq));
  pwi_far_model far (.clk_i(clk), .dma_req_i(dreq), .dma_addr_i(daddr), .dma_gnt_o(dgnt),
    .dma_rdata_o(drdata), .pwm_valid_i(pvalid), .pwm_ack_o(pack), .wait_i(far_wait),
    .reload_cmd_i(reload_cmd), .pwm_reload_o(preload));
  // bus answers against the oldest note
  always @(posedge clk)
  begin
    if (pready === 1'b1)
    begin
      nt = bus_q.pop_front();
      if (nt.rd === 1'b1) `CHK(prdata, nt.dat)
      `CHK(pslverr, nt.err)
    end
  end
  // pwm handovers against the oldest note
  always @(posedge clk)
  begin
    if (pvalid === 1'b1 && pack === 1'b1)
    begin
      last = pwm_q.pop_front();
      `CHK(pwm_ch, last)
    end
  end
  // angle steps, wrap and spacing; grant and interrupt counts
  always @(posedge clk)
  begin
    if (dreq === 1'b1 && dgnt === 1'b1)
      grants++;
    if (irq === 1'b1)
      irqs++;
    if (angle !== prev_angle && rstn === 1'b1)
    begin
      `CHK(angle, (prev_angle == lim) ? 12'h000 : prev_angle + 12'h001)
      if (steps > 0) `CHK(cyc, 8)
      steps++;
      cyc = 0;
    end
    cyc++;
    prev_angle = angle;
  end
  task automatic apb(input logic wr, input logic [6:0] idx, input logic [15:0] wd,
    input logic [15:0] ex, input logic er);
    int n = 0;
    bus_q.push_back('{!wr, {16'h0, ex}, er});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {3'h0, idx, 2'b00};
    pwdata <= {16'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, 16'h0, 1'b0);
  endtask : wr
  task automatic rd(input logic [6:0] idx, input logic [15:0] ex);
    apb(1'b0, idx, 16'h0, ex, 1'b0);
  endtask : rd
  function automatic logic [6:0] ci(input int n, input logic [3:0] s);
    return {3'(CHAN_BLOCK_FIRST + n), s};
  endfunction : ci
  // table line n as the memory holds it
  function automatic logic [31:0] tbl(input int n);
    return (n > 2) ? 32'h0 : {8'h10, 8'(4 * n), 7'h02, 9'h003};
  endfunction : tbl
  task automatic waitg(input int k);
    repeat (300) if (grants < k) @(posedge clk);
  endtask : waitg
  // scale trigger, expecting e with first two channels exchanged when sw
  task automatic kick(input logic sw);
    pwm_q.push_back(sw ? {e[2], e[0], e[1]} : e);
    wr(IDX_TRIG, 16'h0080);
    repeat (60) if (pwm_q.size() != 0) @(posedge clk);
  endtask : kick
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  // watchdog well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  // main sequence
  initial
  begin
    r = $urandom(32'h15077EB1);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 16'h0000);
    apb(1'b0, 7'h7F, 16'h0, 16'h0, 1'b1);
    r = $urandom();
    wr(IDX_WRAP, r[15:0]);
    rd(IDX_WRAP, {4'h0, r[11:0]});
    wr(IDX_SPEED, 16'($urandom() % 52429));
    wr(IDX_PHASE, r[31:16]);
    rd(IDX_PHASE, r[31:16]);
    // speed reload from the shadow only when freshly written
    b = irqs;
    wr(IDX_SHADOW, 16'h1111);
    wr(IDX_TRIG, 16'h0001);
    rd(IDX_SPEED, 16'h1111);
    `CHK(irqs, b + 1)
    wr(IDX_SPEED, 16'h2222);
    wr(IDX_TRIG, 16'h0001);
    rd(IDX_SPEED, 16'h2222);
    // refill all three channels from the table
    wr(IDX_TABLE_BASE, 16'h0100);
    wr(ci(1, SUB_OFFSET), 16'h0004);
    wr(ci(2, SUB_OFFSET), 16'h0008);
    wr(IDX_CONFIG, 16'h0022);
    wr(IDX_TRIG, 16'h0070);
    waitg(3);
    for (int n = 0; n < 3; n++)
    begin
      r = tbl(n);
      rd(ci(n, SUB_LOW_RLD), r[15:0]);
      rd(ci(n, SUB_HIGH_RLD), r[31:16]);
      rd(ci(n, SUB_OFFSET), 16'(4 * n + 4));
    end
    // forced reloads with a slow memory; third channel meets the table end
    far_wait <= 4'h7;
    b = irqs;
    wr(IDX_TRIG, 16'h000E);
    waitg(7);
    `CHK(irqs > b, 1'b1)
    rd(ci(2, SUB_OFFSET), 16'h0004);
    rd(ci(2, SUB_LOW_RLD), 16'(tbl(0)));
    rd(ci(1, SUB_LOW_RLD), 16'(tbl(2)));
    for (int n = 0; n < 3; n++)
    begin
      r = tbl(n);
      rd(ci(n, SUB_LOW), r[15:0]);
      rd(ci(n, SUB_HIGH), r[31:16]);
      e[n] = '{1'b1, 1'b1, {1'b0, r[30:16]}};
    end
    kick(1'b0);
    wr(IDX_CONFIG, 16'h0032);
    kick(1'b1);
    // configured conduction, every code
    wr(ci(0, SUB_HIGH), 16'h9000);
    e[0].amp = 16'h1000;
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_CONFIG, 16'(32'h22 | (c << 2)));
      e[0].high_side = c[1];
      e[0].low_side = c[0];
      kick(1'b0);
    end
    // pwm reload paces the scaler
    pwm_q.push_back(e);
    reload_cmd <= 1'b1;
    @(posedge clk);
    reload_cmd <= 1'b0;
    repeat (60) if (pwm_q.size() != 0) @(posedge clk);
    // dma disabled: a forced reload leaves the reload words alone
    wr(IDX_CONFIG, 16'h0020);
    wr(IDX_TRIG, 16'h0004);
    repeat (20) @(posedge clk);
    `CHK(grants, 7)
    rd(ci(1, SUB_LOW_RLD), 16'(tbl(2)));
    // two phase steps with angle wrap at 1
    lim = 12'h001;
    wr(IDX_WRAP, 16'h0001);
    wr(IDX_SPEED, 16'h8000);
    wr(IDX_CONFIG, 16'h002F);
    repeat (100) if (steps < 2) @(posedge clk);
    wr(IDX_CONFIG, 16'h002E);
    rd(ci(0, SUB_LOW), 16'h0401);
    rd(ci(0, SUB_HIGH), 16'h9004);
    rd(IDX_ANGLE, 16'h0000);
    summarize();
  end
endmodule : testbench
`default_nettype wire
